// ### core/addr_detect.v
// Two-wire bus slave front end: conditions, address match, stretch
// ****************************************************************
// Summary of operation
// - Stop collision as master raises collision pulse
// - Slave active when enabled, never initiates
// - Data bits sampled on clock rising edge
// - Start sets start_seen, Stop sets stop_seen
// - Both flags cleared on reset or disable
// - Ten-bit mode selects one or two bytes
// - Direction 0 receives, 1 transmits
// - Mask ones make address bits don't-care
// - Enforce bit blocks reserved addresses in seven-bit mode
// - Seven-bit compare at eighth falling edge
// - Write address: ack, clear flags, interrupt
// - Read address: ack, set direction, interrupt
// - Read address clears release, holds clock low
// - Release clears on read address regardless of stretch enable; later bytes stretch only if enabled
// - Receive: ack, buffer byte, interrupt; no ack when buffer full
// - Address match raises selection interrupt
// - Ten-bit first byte prefix 11110, write
// - Upper mask bits on first, lower on second
// - Ten-bit bytes acked, second sets matched flag
// - Failed compare ignores bus until Stop or Start
// ****************************************************************
`timescale 1ns/10ps
`default_nettype none
`include "addr_detect_regs.vh"
module addr_detect #(
    parameter FIFO_DEPTH = `FIFO_DEPTH
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Configuration
    input wire module_enable,
    input wire ten_bit_addr_mode,
    input wire reserved_addr_enforce,
    input wire clock_stretch_enable,
    input wire [9:0] own_address,
    input wire [9:0] address_mask,
    // Software clock release and transmit data
    input wire clock_release_set,
    input wire [7:0] transmit_register,
    // Master stop arbitration check from master logic
    input wire master_stop_active,
    // Bus pins
    input wire serial_clock_line_in,
    output reg serial_clock_line_out,
    output reg serial_clock_line_oe,
    input wire serial_data_line_in,
    output reg serial_data_line_out,
    output reg serial_data_line_oe,
    // Receive buffer drain
    output reg receive_valid,
    input wire receive_ready,
    output reg [7:0] receive_buffer,
    // Status
    output reg start_seen,
    output reg stop_seen,
    output reg data_not_addr,
    output reg read_not_write,
    output reg ten_bit_matched,
    output reg clock_release,
    output reg slave_irq,
    output reg bus_collision_irq,
    output reg receive_full
);
    // ****************************************************************
    // Pin synchronisers and edge detection
    // ****************************************************************
    reg scl_meta_reg, scl_sync_reg, scl_prev_reg;
    reg sda_meta_reg, sda_sync_reg, sda_prev_reg;
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            scl_meta_reg <= 1'b1;
            scl_sync_reg <= 1'b1;
            scl_prev_reg <= 1'b1;
            sda_meta_reg <= 1'b1;
            sda_sync_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_meta_reg <= serial_clock_line_in;
            scl_sync_reg <= scl_meta_reg;
            scl_prev_reg <= scl_sync_reg;
            sda_meta_reg <= serial_data_line_in;
            sda_sync_reg <= sda_meta_reg;
            sda_prev_reg <= sda_sync_reg;
        end
    end
    wire scl_rise = scl_sync_reg && !scl_prev_reg;
    wire scl_fall = !scl_sync_reg && scl_prev_reg;
    wire start_det = scl_sync_reg && scl_prev_reg && sda_prev_reg && !sda_sync_reg;
    wire stop_det = scl_sync_reg && scl_prev_reg && !sda_prev_reg && sda_sync_reg;

    // ****************************************************************
    // Address compare functions
    // ****************************************************************
    // Masked equality: ones in mask are don't-care
    function masked_eq;
        input [7:0] a;
        input [7:0] b;
        input [7:0] m;
        begin
            masked_eq = &((~(a ^ b)) | m);
        end
    endfunction
    // Reserved seven-bit addresses: 0000xxx and 1111xxx
    function is_reserved7;
        input [6:0] a;
        begin
            is_reserved7 = (a[6:3] == 4'h0) || (a[6:3] == 4'hf);
        end
    endfunction

    // ****************************************************************
    // Slave sequencer
    // ****************************************************************
    reg [2:0] state_reg;
    reg [3:0] bit_cnt_reg;
    reg [7:0] shift_reg;
    reg ack_pending_reg;      // Drive ack during ninth clock
    reg [7:0] tx_shift_reg;
    reg tx_active_reg;
    reg master_ack_reg;
    reg stretch_reg;
    reg fifo_in_valid;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [7:0] fifo_out_data;
    wire [7:0] rx_next = {shift_reg[6:0], sda_sync_reg};
    // Compare the byte already shifted in; the line still shows bit 0 at the fall
    wire match7 = masked_eq({1'b0, shift_reg[7:1]}, {1'b0, own_address[6:0]}, {1'b0, address_mask[6:0]})
        && !(reserved_addr_enforce && is_reserved7(shift_reg[7:1]));
    wire match10_hi = (shift_reg[7:3] == `TEN_BIT_PREFIX) && !shift_reg[0]
        && masked_eq({6'h00, shift_reg[2:1]}, {6'h00, own_address[9:8]}, {6'h00, address_mask[9:8]});
    wire match10_lo = masked_eq(shift_reg, own_address[7:0], address_mask[7:0]);

    // Main sequencer; bit count counts rising edges within a byte
    always @(posedge sys_clk) begin
        if (!rst_n || !module_enable) begin
            state_reg <= `ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ack_pending_reg <= 1'b0;
            tx_shift_reg <= 8'h00;
            tx_active_reg <= 1'b0;
            master_ack_reg <= 1'b0;
            stretch_reg <= 1'b0;
            start_seen <= 1'b0;
            stop_seen <= 1'b0;
            data_not_addr <= 1'b0;
            read_not_write <= 1'b0;
            ten_bit_matched <= 1'b0;
            clock_release <= 1'b1;
            slave_irq <= 1'b0;
            fifo_in_valid <= 1'b0;
            receive_full <= 1'b0;
        end else begin
            slave_irq <= 1'b0;
            fifo_in_valid <= 1'b0;
            receive_full <= !fifo_in_ready;
            // Software release ends the stretch after loading data
            if (clock_release_set) begin
                clock_release <= 1'b1;
                if (stretch_reg) begin
                    tx_shift_reg <= transmit_register;
                    tx_active_reg <= 1'b1;
                    stretch_reg <= 1'b0;
                end
            end
            if (start_det) begin
                start_seen <= 1'b1;
                stop_seen <= 1'b0;
                state_reg <= `ST_ADDR1;
                bit_cnt_reg <= 4'h0;
                ack_pending_reg <= 1'b0;
                tx_active_reg <= 1'b0;
                stretch_reg <= 1'b0;
                ten_bit_matched <= 1'b0;
            end else if (stop_det) begin
                stop_seen <= 1'b1;
                start_seen <= 1'b0;
                state_reg <= `ST_IDLE;
                ack_pending_reg <= 1'b0;
                tx_active_reg <= 1'b0;
                stretch_reg <= 1'b0;
            end else if (state_reg != `ST_IDLE && state_reg != `ST_IGNORE) begin
                if (scl_rise) begin
                    if (bit_cnt_reg < `BITS_PER_BYTE) begin
                        shift_reg <= rx_next;
                    end else if (state_reg == `ST_READ) begin
                        master_ack_reg <= sda_sync_reg;
                    end
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                end
                if (scl_fall && bit_cnt_reg == `BITS_PER_BYTE) begin
                    // Eighth falling edge: evaluate byte
                    case (state_reg)
                        `ST_ADDR1: begin
                            if (!ten_bit_addr_mode) begin
                                if (match7) begin
                                    ack_pending_reg <= 1'b1;
                                    data_not_addr <= 1'b0;
                                    read_not_write <= shift_reg[0];
                                end else begin
                                    state_reg <= `ST_IGNORE;
                                end
                            end else if (match10_hi) begin
                                ack_pending_reg <= 1'b1;
                                data_not_addr <= 1'b0;
                                read_not_write <= 1'b0;
                            end else begin
                                state_reg <= `ST_IGNORE;
                            end
                        end
                        `ST_ADDR2: begin
                            if (match10_lo) begin
                                ack_pending_reg <= 1'b1;
                            end else begin
                                state_reg <= `ST_IGNORE;
                            end
                        end
                        `ST_WRITE: begin
                            // Full buffer is an overrun: no ack
                            if (fifo_in_ready) begin
                                ack_pending_reg <= 1'b1;
                                fifo_in_valid <= 1'b1;
                                data_not_addr <= 1'b1;
                            end
                        end
                        `ST_READ: begin
                            tx_active_reg <= 1'b0;
                        end
                        default: begin
                            state_reg <= `ST_IGNORE;
                        end
                    endcase
                end
                if (scl_fall && bit_cnt_reg == `ACK_BIT_INDEX) begin
                    // Ninth falling edge: interrupt if the byte was acked, then move on
                    ack_pending_reg <= 1'b0;
                    bit_cnt_reg <= 4'h0;
                    if (ack_pending_reg) begin
                        slave_irq <= 1'b1;
                    end
                    case (state_reg)
                        `ST_ADDR1: begin
                            if (ten_bit_addr_mode) begin
                                state_reg <= `ST_ADDR2;
                            end else if (read_not_write) begin
                                state_reg <= `ST_READ;
                                clock_release <= 1'b0;
                                stretch_reg <= 1'b1;
                            end else begin
                                state_reg <= `ST_WRITE;
                            end
                        end
                        `ST_ADDR2: begin
                            ten_bit_matched <= 1'b1;
                            state_reg <= `ST_WRITE;
                        end
                        `ST_READ: begin
                            // Master ack asks for next byte; stretch again if stretch enable is set
                            if (!master_ack_reg && clock_stretch_enable) begin
                                clock_release <= 1'b0;
                                stretch_reg <= 1'b1;
                            end else if (!master_ack_reg) begin
                                tx_shift_reg <= transmit_register;
                                tx_active_reg <= 1'b1;
                            end else begin
                                state_reg <= `ST_IGNORE;
                            end
                        end
                        default: begin
                            state_reg <= state_reg;
                        end
                    endcase
                end else if (scl_fall && state_reg == `ST_READ && tx_active_reg) begin
                    tx_shift_reg <= {tx_shift_reg[6:0], 1'b1};
                end
            end
        end
    end

    // ****************************************************************
    // Pin drivers and collision detection
    // ****************************************************************
    // Open drain: out is always low, enable pulls the line
    always @(posedge sys_clk) begin
        if (!rst_n || !module_enable) begin
            serial_clock_line_out <= 1'b0;
            serial_clock_line_oe <= 1'b0;
            serial_data_line_out <= 1'b0;
            serial_data_line_oe <= 1'b0;
            bus_collision_irq <= 1'b0;
        end else begin
            serial_clock_line_out <= 1'b0;
            serial_data_line_out <= 1'b0;
            // Release drops the hold in the same cycle as the flag rises
            serial_clock_line_oe <= stretch_reg && !clock_release_set && !scl_sync_reg;
            // Ack and data stand until a falling edge, never change while the clock is high
            serial_data_line_oe <= ack_pending_reg
                || (state_reg == `ST_READ && tx_active_reg && !tx_shift_reg[7]);
            // Stop released high but line held low by another master
            bus_collision_irq <= master_stop_active && scl_sync_reg && sda_prev_reg
                && !sda_sync_reg;
        end
    end

    // ****************************************************************
    // Receive buffer path
    // ****************************************************************
    // Output stage register keeps outputs straight from flops
    wire take = fifo_out_valid && (!receive_valid || receive_ready);
    always @(posedge sys_clk) begin
        if (!rst_n || !module_enable) begin
            receive_valid <= 1'b0;
            receive_buffer <= 8'h00;
        end else if (take) begin
            receive_valid <= 1'b1;
            receive_buffer <= fifo_out_data;
        end else if (receive_ready) begin
            receive_valid <= 1'b0;
        end
    end

    byte_fifo #(
        .WIDTH(`FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH),
        .AW(3)
    ) rx_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .flush(!module_enable),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(shift_reg),
        .out_valid(fifo_out_valid),
        .out_ready(take),
        .out_data(fifo_out_data)
    );
endmodule // addr_detect
`default_nettype wire

// ### core/addr_detect_regs.vh
// Constants for the two-wire slave address detector
`ifndef ADDR_DETECT_REGS_VH
`define ADDR_DETECT_REGS_VH
`define ADDR_WIDTH 10
`define TEN_BIT_PREFIX 5'h1e
`define FIFO_DEPTH 8
`define FIFO_WIDTH 8
`define BITS_PER_BYTE 4'h8
`define ACK_BIT_INDEX 4'h9
`define ST_IDLE 3'h0
`define ST_ADDR1 3'h1
`define ST_ADDR2 3'h2
`define ST_WRITE 3'h3
`define ST_READ 3'h4
`define ST_IGNORE 3'h5
`endif

// ### core/byte_fifo.v
// Small synchronous FIFO for received bytes
`timescale 1ns/10ps
`default_nettype none
module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    input wire flush,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW:0] wr_ptr_reg;
    reg [AW:0] rd_ptr_reg;
    wire [AW:0] used;
    assign used = wr_ptr_reg - rd_ptr_reg;
    assign in_ready = (used != DEPTH[AW:0]);
    assign out_valid = (used != {(AW+1){1'b0}});
    assign out_data = mem_reg[rd_ptr_reg[AW-1:0]];
    // Pointers advance only on accepted handshakes
    always @(posedge sys_clk) begin
        if (!rst_n || flush) begin
            wr_ptr_reg <= {(AW+1){1'b0}};
            rd_ptr_reg <= {(AW+1){1'b0}};
        end else begin
            if (in_valid && in_ready) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (out_valid && out_ready) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end
    // Storage has no reset, contents qualified by pointers
    always @(posedge sys_clk) begin
        if (in_valid && in_ready) begin
            mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end
endmodule // byte_fifo
`default_nettype wire

// ### test/addr_detect_sva.sv
// Port-level checker for the two-wire slave address detector
`timescale 1ns/10ps
`default_nettype none
module addr_detect_sva (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Controls
    input wire logic module_enable,
    input wire logic ten_bit_addr_mode,
    input wire logic clock_release_set,
    input wire logic master_stop_active,
    // Pins
    input wire logic serial_clock_line_in,
    input wire logic serial_data_line_in,
    input wire logic serial_clock_line_oe,
    input wire logic serial_data_line_oe,
    // Status
    input wire logic receive_valid,
    input wire logic receive_full,
    input wire logic start_seen,
    input wire logic stop_seen,
    input wire logic read_not_write,
    input wire logic ten_bit_matched,
    input wire logic clock_release,
    input wire logic slave_irq,
    input wire logic bus_collision_irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Flag edges must match the line levels that caused them
    property p_start; $rose(start_seen) |-> serial_clock_line_in && !serial_data_line_in; endproperty
    a_start: assert property (p_start) else $error("start flag without start levels");
    property p_stop; $rose(stop_seen) |-> serial_clock_line_in && serial_data_line_in; endproperty
    a_stop: assert property (p_stop) else $error("stop flag without stop levels");
    property p_excl; !(start_seen && stop_seen); endproperty
    a_excl: assert property (p_excl) else $error("start and stop flags together");
    property p_off; !module_enable |=> !start_seen && !stop_seen; endproperty
    a_off: assert property (p_off) else $error("flags kept while disabled");
    property p_quiet; !module_enable |=> !serial_clock_line_oe && !serial_data_line_oe; endproperty
    a_quiet: assert property (p_quiet) else $error("pins driven while disabled");
    property p_irq; slave_irq |=> !slave_irq; endproperty
    a_irq: assert property (p_irq) else $error("slave interrupt longer than one cycle");
    property p_ten; $rose(ten_bit_matched) |-> ten_bit_addr_mode; endproperty
    a_ten: assert property (p_ten) else $error("ten-bit flag in seven-bit mode");
    property p_col; bus_collision_irq |-> $past(master_stop_active); endproperty
    a_col: assert property (p_col) else $error("collision outside own stop");
    property p_full; receive_full |-> receive_valid; endproperty
    a_full: assert property (p_full) else $error("full buffer shows no data");
    property p_hold; serial_clock_line_oe |-> !clock_release; endproperty
    a_hold: assert property (p_hold) else $error("clock held while released");
    property p_rel; clock_release_set |=> clock_release; endproperty
    a_rel: assert property (p_rel) else $error("release request ignored");
    property p_auto; $fell(clock_release) |-> ##[0:8] read_not_write; endproperty
    a_auto: assert property (p_auto) else $error("release cleared without read");
    // Main scenarios
    c_read: cover property (slave_irq && read_not_write);
    c_ten: cover property ($rose(ten_bit_matched));
    c_col: cover property (bus_collision_irq);
endmodule // addr_detect_sva
`default_nettype wire

// ### test/bus_master_model.sv
// Behavioural bus master on the far side of the slave
`timescale 1ns/10ps
`default_nettype none
module bus_master_model (
    // Pacing clock
    input wire logic sys_clk,
    // Resolved line levels
    input wire logic scl,
    input wire logic sda,
    // Pulls, high drags the line low
    output logic scl_low,
    output logic sda_low
);
    logic hung = 1'b0;
    int stall;
    // Idle bus, both lines left to the pull-ups
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    // Release the clock, wait out a stretch, sample late in the high phase
    task automatic pulse(output logic s);
        scl_low <= 1'b0;
        stall = 0;
        do begin
            tick(1);
            stall++;
        end while (scl !== 1'b1 && stall < 5000);
        if (stall >= 5000) hung = 1'b1;
        tick(2);
        s = sda;
        tick(1);
        scl_low <= 1'b1;
    endtask
    // Data falls while the clock is high; clock stays low afterwards
    task automatic start_cond;
        tick(2);
        sda_low <= 1'b0;
        tick(6);
        scl_low <= 1'b0;
        tick(6);
        sda_low <= 1'b1;
        tick(8);
        scl_low <= 1'b1;
        tick(4);
    endtask
    // Data rises while the clock is high; bus left idle
    task automatic stop_cond;
        tick(2);
        sda_low <= 1'b1;
        tick(4);
        scl_low <= 1'b0;
        tick(6);
        sda_low <= 1'b0;
        tick(8);
    endtask
    // Data pull for a competing master
    task automatic pull_sda(input logic v);
        sda_low <= v;
    endtask
    // Eight bits most significant first, then the acknowledge slot
    task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            tick(2);
            sda_low <= !tx[i];
            tick(4);
            pulse(s);
            rx[i] = s;
        end
        tick(2);
        sda_low <= ack_in;
        tick(4);
        pulse(s);
        ack = !s;
    endtask
endmodule // bus_master_model
`default_nettype wire

// ### test/addr_detect_tb_top.sv
// Self-checking bench for the two-wire slave address detector
`timescale 1ns/10ps
`default_nettype none
module addr_detect_tb_top;
    // ****
    // Stimulus, design and far-side master
    // ****
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic module_enable = 1'b0;
    logic ten_bit_addr_mode = 1'b0;
    logic reserved_addr_enforce = 1'b0;
    logic clock_stretch_enable = 1'b0;
    logic [9:0] own_address = 10'h000;
    logic [9:0] address_mask = 10'h000;
    logic clock_release_set = 1'b0;
    logic [7:0] transmit_register = 8'h00;
    logic master_stop_active = 1'b0;
    logic receive_ready = 1'b0;
    wire scl_low, sda_low, serial_clock_line_out, serial_clock_line_oe, serial_data_line_out, serial_data_line_oe;
    wire receive_valid, receive_full, start_seen, stop_seen, data_not_addr, read_not_write;
    wire ten_bit_matched, clock_release, slave_irq, bus_collision_irq;
    wire [7:0] receive_buffer;
    // Open-drain lines with pull-ups
    wire serial_clock_line_in = !(scl_low || serial_clock_line_oe);
    wire serial_data_line_in = !(sda_low || serial_data_line_oe);
    int mismatches = 0;
    int checks_done = 0;
    int irq_cnt = 0;
    int col_cnt = 0;
    int irq0, n;
    logic [7:0] exp_q[$];
    logic [7:0] rx, d;
    logic [6:0] own7;
    logic [9:0] own10;
    logic ack;
    always #2 sys_clk = ~sys_clk;
    addr_detect dut (.*);
    bus_master_model m (.sys_clk(sys_clk), .scl(serial_clock_line_in), .sda(serial_data_line_in),
        .scl_low(scl_low), .sda_low(sda_low));
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask
    // Let the edge's updates land before looking
    task automatic settle(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic addr7(input logic [6:0] a, input logic rd, output logic ok);
        m.start_cond();
        m.xfer({a, rd}, 1'b0, rx, ok);
        settle(8);
    endtask
    task automatic done(input string s);
        $display("Finished: %s", s);
    endtask
    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Count pulses; each drained byte is matched with the oldest note
    always @(posedge sys_clk) begin
        if (slave_irq === 1'b1) irq_cnt <= irq_cnt + 1;
        if (bus_collision_irq === 1'b1) col_cnt <= col_cnt + 1;
        if (receive_valid === 1'b1 && receive_ready === 1'b1) begin
            if (exp_q.size() > 0) chk_byte(receive_buffer, exp_q.pop_front());
            else chk_bit(1'b1, 1'b0);
        end
    end
    initial begin
        void'($urandom(48));
        own7 = 7'h10 + 7'($urandom % 96);
        own10 = 10'($urandom);
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        module_enable <= 1'b1;
        own_address <= {3'h0, own7};
        settle(4);
        // Write address, then overfill the buffer while software stalls
        irq0 = irq_cnt;
        addr7(own7, 1'b0, ack);
        chk_bit(ack, 1'b1);
        chk_bit(read_not_write, 1'b0);
        chk_bit(data_not_addr, 1'b0);
        chk_bit(start_seen, 1'b1);
        chk_byte(8'(irq_cnt - irq0), 8'h01);
        for (int k = 0; k < 10; k++) begin
            d = 8'($urandom);
            m.xfer(d, 1'b0, rx, ack);
            if (ack === 1'b1) exp_q.push_back(d);
            if (k < 8) chk_bit(ack, 1'b1);
            if (k == 9) chk_bit(ack, 1'b0);
        end
        settle(8);
        chk_bit(receive_full, 1'b1);
        chk_bit(data_not_addr, 1'b1);
        chk_byte(8'(irq_cnt - irq0), 8'(exp_q.size() + 1));
        m.stop_cond();
        settle(2);
        chk_bit(stop_seen, 1'b1);
        chk_bit(start_seen, 1'b0);
        @(posedge sys_clk);
        receive_ready <= 1'b1;
        for (n = 0; n < 100 && exp_q.size() > 0; n++) @(posedge sys_clk);
        receive_ready <= 1'b0;
        settle(2);
        chk_byte(8'(exp_q.size()), 8'h00);
        chk_bit(receive_valid, 1'b0);
        done("write and buffer fill");
        // Masked read address, clock held until software releases it
        address_mask <= 10'h002;
        for (int se = 0; se < 2; se++) begin
            clock_stretch_enable <= 1'(se);
            addr7(own7 ^ 7'h02, 1'b1, ack);
            chk_bit(ack, 1'b1);
            chk_bit(read_not_write, 1'b1);
            chk_bit(clock_release, 1'b0);
            settle(20);
            chk_bit(serial_clock_line_oe, 1'b1);
            d = 8'($urandom);
            @(posedge sys_clk);
            transmit_register <= d;
            clock_release_set <= 1'b1;
            @(posedge sys_clk);
            clock_release_set <= 1'b0;
            m.xfer(8'hff, 1'b0, rx, ack);
            chk_byte(rx, d);
            m.stop_cond();
        end
        done("read with stretch");
        // Wrong address ignored until Stop; repeated Start begins afresh
        address_mask <= 10'h000;
        addr7(own7 ^ 7'h01, 1'b0, ack);
        chk_bit(ack, 1'b0);
        m.xfer({own7, 1'b0}, 1'b0, rx, ack);
        chk_bit(ack, 1'b0);
        m.stop_cond();
        addr7(own7, 1'b0, ack);
        addr7(own7, 1'b0, ack);
        chk_bit(ack, 1'b1);
        m.stop_cond();
        done("mismatch and restart");
        // Reserved address reached only through the mask
        own_address <= 10'h078;
        address_mask <= 10'h007;
        for (int e = 0; e < 2; e++) begin
            reserved_addr_enforce <= 1'(e);
            addr7(7'h7c, 1'b0, ack);
            chk_bit(ack, 1'(1 - e));
            m.stop_cond();
        end
        done("reserved address");
        // Ten-bit address, failing second byte first, then a masked match
        ten_bit_addr_mode <= 1'b1;
        own_address <= own10;
        address_mask <= 10'h201;
        for (int b = 0; b < 2; b++) begin
            irq0 = irq_cnt;
            m.start_cond();
            m.xfer({5'h1e, own10[9:8] ^ 2'b10, 1'b0}, 1'b0, rx, ack);
            chk_bit(ack, 1'b1);
            m.xfer(own10[7:0] ^ (b == 1 ? 8'h01 : 8'h02), 1'b0, rx, ack);
            settle(8);
            chk_bit(ack, 1'(b));
            chk_bit(ten_bit_matched, 1'(b));
            chk_byte(8'(irq_cnt - irq0), 8'(1 + b));
            m.stop_cond();
        end
        done("ten-bit address");
        // Another master holds data low during our Stop, then a disable
        @(posedge sys_clk);
        master_stop_active <= 1'b1;
        m.tick(8);
        m.pull_sda(1'b1);
        m.tick(12);
        master_stop_active <= 1'b0;
        chk_byte(8'(col_cnt), 8'h01);
        module_enable <= 1'b0;
        settle(3);
        chk_bit(start_seen, 1'b0);
        chk_bit(stop_seen, 1'b0);
        @(posedge sys_clk);
        module_enable <= 1'b1;
        m.tick(10);
        m.pull_sda(1'b0);
        settle(10);
        chk_bit(m.hung, 1'b0);
        chk_byte({6'h00, serial_clock_line_out, serial_data_line_out}, 8'h00);
        done("collision and disable");
        print_verdict();
    end
endmodule // addr_detect_tb_top
bind addr_detect addr_detect_sva chk (.*);
`default_nettype wire
